/* dma_flags_pkg.sv */
/*
  Constants for the DMA channel event-flag and setup block: register indices,
  flag positions, reset values and sizes.
  Assumes a 32-bit register port with one-cycle read latency on a 20 MHz clock.
*/
package dma_flags_pkg;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] REG_EVENT_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_SRC_START = 4'h4;
  localparam logic [ADDR_W-1:0] REG_DST_START = 4'h8;
  localparam logic [ADDR_W-1:0] REG_SRC_SIZE = 4'hc;
  localparam int FLAG_W = 5;
  localparam int ADDR_ERR_BIT = 0;
  localparam int ABORT_BIT = 1;
  localparam int CELL_DONE_BIT = 2;
  localparam int BLOCK_DONE_BIT = 3;
  localparam int HALF_FULL_BIT = 4;
  localparam int ENABLE_LSB = 16;
  localparam int SIZE_W = 16;
  localparam logic [31:0] ADDR_RESET = 32'h00000000;
  localparam logic [SIZE_W-1:0] SIZE_RESET = 16'h0000;
  localparam logic [FLAG_W-1:0] FLAG_RESET = 5'h00;
endpackage : dma_flags_pkg

/* event_flag.sv */
/*
  One sticky event flag with its interrupt enable.
  Assumes the parent decodes the write strobe for the flag's register.
*/
module event_flag
  import dma_flags_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic eventSeen,
  input wire logic wrEn,
  input wire logic wrFlag,
  input wire logic wrEnable,
  output logic flag,
  output logic enable,
  output logic request
);
  logic flag_ff, nxt_flag;
  logic enable_ff, nxt_enable;

  always_comb begin
    // A new event beats a clearing write in the same cycle.
    nxt_flag = flag_ff;
    if (wrEn && !wrFlag) begin
      nxt_flag = 1'b0;
    end
    if (eventSeen) begin
      nxt_flag = 1'b1;
    end
    nxt_enable = wrEn ? wrEnable : enable_ff;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      flag_ff <= 1'b0;
      enable_ff <= 1'b0;
    end else begin
      flag_ff <= nxt_flag;
      enable_ff <= nxt_enable;
    end
  end

  assign flag = flag_ff;
  assign enable = enable_ff;
  assign request = flag_ff & enable_ff;
endmodule : event_flag

/* dma_channel_flags_and_setup.sv */
/*
  Event flags, start addresses and source size of one DMA channel.
  Assumes the channel engine supplies byte-move strobes, pointers, sizes,
  the pattern-match strobe, an address check and the live interrupt number.
  Software writes physical addresses into the start registers. 
*/
module dma_channel_flags_and_setup
  import dma_flags_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  input wire logic byteMoved,
  input wire logic [SIZE_W-1:0] dstBytePointer,
  input wire logic [SIZE_W-1:0] dstByteCount,
  input wire logic [SIZE_W-1:0] cellByteCount,
  input wire logic patternMatch,
  input wire logic srcAddrInvalid,
  input wire logic dstAddrInvalid,
  input wire logic irqValid,
  input wire logic [7:0] irqNumber,
  input wire logic [7:0] abortIrqSelect,
  input wire logic abortIrqEnable,
  input wire logic channelEnable,
  output logic abortTransfer,
  output logic [31:0] srcStartAddr,
  output logic [31:0] dstStartAddr,
  output logic [16:0] srcBytes,
  output logic irqOut
);
  // Setup words kept for software and the engine.
  logic [31:0] srcAddr_ff, nxt_srcAddr;
  logic [31:0] dstAddr_ff, nxt_dstAddr;
  logic [SIZE_W-1:0] srcSize_ff, nxt_srcSize;
  logic [31:0] rdData_ff, nxt_rdData;

  // Byte counters of the running block and of the running cell.
  logic [16:0] moved_ff, nxt_moved;
  logic [16:0] cellCnt_ff, nxt_cellCnt;
  logic [16:0] movedInc;
  logic [16:0] cellInc;
  logic [16:0] dstBytes;
  logic [16:0] cellBytes;
  logic [16:0] blockBytes;
  logic [16:0] dstNextPtr;
  logic [16:0] dstHalf;

  // Events seen in the current cycle.
  logic byteStep;
  logic cellHit;
  logic blockHit;
  logic halfHit;
  logic patternHit;
  logic addrErrHit;
  logic restartCount;
  logic [FLAG_W-1:0] events;
  logic [FLAG_W-1:0] flags;
  logic [FLAG_W-1:0] enables;
  logic [FLAG_W-1:0] requests;

  // Register port decode.
  logic ctrlWr;
  logic srcAddrWr;
  logic dstAddrWr;
  logic srcSizeWr;
  logic ctrlRd;
  logic srcAddrRd;
  logic dstAddrRd;
  logic srcSizeRd;
  logic [31:0] ctrlWord;

  // A size field of zero stands for the full 64 KiB.
  function automatic logic [16:0] size_bytes(input logic [SIZE_W-1:0] v);
    size_bytes = (v == SIZE_RESET) ? 17'h10000 : {1'b0, v};
  endfunction : size_bytes

  // Sizes are carried on 17 bits so that the full 64 KiB stays representable.
  assign srcBytes = size_bytes(srcSize_ff);
  assign dstBytes = size_bytes(dstByteCount);
  assign cellBytes = size_bytes(cellByteCount);
  assign blockBytes = (srcBytes > dstBytes) ? srcBytes : dstBytes;

  // The engine reports the pointer before the byte lands, so one is added here.
  // Comparing the landed position makes the half-full event fire exactly once.
  assign dstNextPtr = {1'b0, dstBytePointer} + 17'h00001;
  assign dstHalf = dstBytes >> 1;
  assign movedInc = moved_ff + 17'h00001;
  assign cellInc = cellCnt_ff + 17'h00001;

  assign abortTransfer = channelEnable && abortIrqEnable && irqValid && (irqNumber == abortIrqSelect);

  // A stopped channel raises no event, so stale engine strobes cannot set flags.
  assign byteStep = channelEnable && byteMoved;
  assign cellHit = byteStep && (cellInc == cellBytes);
  assign blockHit = byteStep && (movedInc == blockBytes);
  assign halfHit = byteStep && (dstNextPtr == dstHalf);
  assign patternHit = channelEnable && patternMatch;
  assign addrErrHit = channelEnable && (srcAddrInvalid || dstAddrInvalid);
  assign restartCount = !channelEnable || patternHit || abortTransfer || blockHit;

  always_comb begin
    events = '0;
    events[ADDR_ERR_BIT] = addrErrHit;
    events[ABORT_BIT] = abortTransfer;
    events[CELL_DONE_BIT] = cellHit;
    events[BLOCK_DONE_BIT] = blockHit || patternHit;
    events[HALF_FULL_BIT] = halfHit;
  end

  // Block counter: a new block starts after completion, pattern match or abort, and it holds at zero while the channel is disabled.
  always_comb begin
    nxt_moved = moved_ff;
    if (byteStep) begin
      nxt_moved = movedInc;
    end
    if (restartCount) begin
      nxt_moved = '0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      moved_ff <= '0;
    end else begin
      moved_ff <= nxt_moved;
    end
  end

  // Cell counter: it restarts with the block so that cells stay aligned to it.
  always_comb begin
    nxt_cellCnt = cellCnt_ff;
    if (byteStep) begin
      nxt_cellCnt = cellInc;
    end
    if (cellHit || restartCount) begin
      nxt_cellCnt = '0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cellCnt_ff <= '0;
    end else begin
      cellCnt_ff <= nxt_cellCnt;
    end
  end

  // Offsets are decoded once; unmapped offsets match no strobe at all.
  assign ctrlWr = regWr && (regAddr == REG_EVENT_CTRL);
  assign srcAddrWr = regWr && (regAddr == REG_SRC_START);
  assign dstAddrWr = regWr && (regAddr == REG_DST_START);
  assign srcSizeWr = regWr && (regAddr == REG_SRC_SIZE);
  assign ctrlRd = regRd && (regAddr == REG_EVENT_CTRL);
  assign srcAddrRd = regRd && (regAddr == REG_SRC_START);
  assign dstAddrRd = regRd && (regAddr == REG_DST_START);
  assign srcSizeRd = regRd && (regAddr == REG_SRC_SIZE);

  genvar g;
  generate
    for (g = 0; g < FLAG_W; g++) begin : gFlag
      event_flag uFlag (
        .clock(clock),
        .rst(rst),
        .eventSeen(events[g]),
        .wrEn(ctrlWr),
        .wrFlag(regWrData[g]),
        .wrEnable(regWrData[ENABLE_LSB+g]),
        .flag(flags[g]),
        .enable(enables[g]),
        .request(requests[g])
      );
    end
  endgenerate

  assign irqOut = |requests;

  // Source start address, written as a whole word.
  always_comb begin
    nxt_srcAddr = srcAddr_ff;
    if (srcAddrWr) begin
      nxt_srcAddr = regWrData;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      srcAddr_ff <= ADDR_RESET;
    end else begin
      srcAddr_ff <= nxt_srcAddr;
    end
  end

  // Destination start address, written as a whole word.
  always_comb begin
    nxt_dstAddr = dstAddr_ff;
    if (dstAddrWr) begin
      nxt_dstAddr = regWrData;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      dstAddr_ff <= ADDR_RESET;
    end else begin
      dstAddr_ff <= nxt_dstAddr;
    end
  end

  // Source size: the upper half of the written word is dropped.
  always_comb begin
    nxt_srcSize = srcSize_ff;
    if (srcSizeWr) begin
      nxt_srcSize = regWrData[SIZE_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      srcSize_ff <= SIZE_RESET;
    end else begin
      srcSize_ff <= nxt_srcSize;
    end
  end

  // Event control word: flags in the low half, enables in the high half.
  always_comb begin
    ctrlWord = '0;
    ctrlWord[ENABLE_LSB +: FLAG_W] = enables;
    ctrlWord[FLAG_W-1:0] = flags;
  end

  // Read data stand for one cycle only; idle cycles and unmapped offsets read zero,
  // which lets software and checkers tell a stale word from a fresh one.
  always_comb begin
    nxt_rdData = '0;
    if (ctrlRd) begin
      nxt_rdData = ctrlWord;
    end
    if (srcAddrRd) begin
      nxt_rdData = srcAddr_ff;
    end
    if (dstAddrRd) begin
      nxt_rdData = dstAddr_ff;
    end
    if (srcSizeRd) begin
      nxt_rdData = {16'h0000, srcSize_ff};
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdData_ff <= '0;
    end else begin
      rdData_ff <= nxt_rdData;
    end
  end

  // Registered outputs only, so the engine never sees a half-written word.
  assign regRdData = rdData_ff;
  assign srcStartAddr = srcAddr_ff;
  assign dstStartAddr = dstAddr_ff;
endmodule : dma_channel_flags_and_setup

/* dma_channel_flags_and_setup_assertions.sv */
/* Port checks of the channel flag block. Assumes a bind to every instance of the block. */
module dma_flags_checker
  import dma_flags_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdData,
  input wire logic [31:0] srcStartAddr,
  input wire logic [16:0] srcBytes,
  input wire logic irqOut
);
  timeunit 1ns / 1ns;
  logic [15:0] wd;
  always_ff @(posedge clock) wd <= regWrData[15:0];
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  property p_rd; regRd && regAddr == REG_SRC_SIZE |=> regRdData[31:16] == 16'h0; endproperty
  a_rd: assert property (p_rd) else $error("size top");
  property p_rz; !regRd |=> regRdData == 32'h0; endproperty
  a_rz: assert property (p_rz) else $error("idle read");
  property p_sz; srcBytes[16] == (srcBytes[15:0] == 16'h0); endproperty
  a_sz: assert property (p_sz) else $error("size zero");
  property p_zw; regWr && regAddr == REG_SRC_SIZE |=> srcBytes[15:0] == wd; endproperty
  a_zw: assert property (p_zw) else $error("size write");
  property p_zh; !(regWr && regAddr == REG_SRC_SIZE) |=> $stable(srcBytes); endproperty
  a_zh: assert property (p_zh) else $error("size hold");
  property p_aw; regWr && regAddr == REG_SRC_START |=> srcStartAddr == $past(regWrData); endproperty
  a_aw: assert property (p_aw) else $error("addr write");
  property p_ah; !(regWr && regAddr == REG_SRC_START) |=> $stable(srcStartAddr); endproperty
  a_ah: assert property (p_ah) else $error("addr hold");
  property p_fl; $fell(irqOut) |-> $past(regWr) || $past(rst); endproperty
  a_fl: assert property (p_fl) else $error("flag drop");
  c_ctl: cover property (regWr && regAddr == REG_EVENT_CTRL);
  c_irq: cover property ($rose(irqOut));
  c_fl: cover property ($fell(irqOut));
endmodule : dma_flags_checker
bind dma_channel_flags_and_setup dma_flags_checker chk_u(.clock(clock), .rst(rst), .regAddr(regAddr),
  .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
  .srcStartAddr(srcStartAddr), .srcBytes(srcBytes), .irqOut(irqOut));

/* engine_model.sv */
/* Engine stand-in that sends len byte moves after go. Assumes go lasts one cycle. */
module engine_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic go,
  input wire logic [7:0] len,
  output logic byteMoved,
  output logic [15:0] ptr
);
  timeunit 1ns / 1ns;
  logic [7:0] left;
  assign byteMoved = left != 8'h0;
  always_ff @(posedge clock) left <= rst ? 8'h0 : go ? len : left - byteMoved;
  always_ff @(posedge clock) ptr <= rst ? 16'h0 : ptr + byteMoved;
endmodule : engine_model

/* dma_channel_flags_and_setup_tb.sv */
/* Bench of the channel flag block. Assumes the engine model feeds the byte moves. */
module dma_channel_flags_and_setup_tb
  import dma_flags_pkg::*;
;
  timeunit 1ns / 1ns;
  logic clock = 0, rst = 1, regWr = 0, regRd = 0, go = 0, channelEnable = 1, byteMoved, irqOut;
  logic abortTransfer;
  logic [31:0] srcStartAddr, dstStartAddr;
  logic [3:0] regAddr = 4'h0, evt = 4'h0;
  logic [31:0] regWrData = 32'h0, regRdData;
  logic [16:0] srcBytes;
  logic [15:0] ptr;
  logic [7:0] len = 8'h0;
  int error_cnt = 0, samples_checked = 0;
  engine_model eng_u(.clock(clock), .rst(rst), .go(go), .len(len), .byteMoved(byteMoved), .ptr(ptr));
  dma_channel_flags_and_setup dut_u(.clock(clock), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .byteMoved(byteMoved), .dstBytePointer(ptr),
    .dstByteCount(16'h8), .cellByteCount(16'h2), .patternMatch(evt[3]), .srcAddrInvalid(evt[2]),
    .dstAddrInvalid(evt[1]), .irqValid(evt[0]), .irqNumber(8'h2a), .abortIrqSelect(8'h2a),
    .abortIrqEnable(1'b1), .channelEnable(channelEnable), .abortTransfer(abortTransfer),
    .srcStartAddr(srcStartAddr), .dstStartAddr(dstStartAddr), .srcBytes(srcBytes), .irqOut(irqOut));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    error_cnt += int'(g !== e);
    if (g !== e) $display("[ERR] %s expected %h seen %h", n, e, g);
  endtask : chk
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clock);
    regWr <= w;
    regRd <= !w;
    regAddr <= a;
    regWrData <= d;
    @(posedge clock);
    regWr <= 1'b0;
    regRd <= 1'b0;
    #1 if (!w) chk($sformatf("reg %h", a), d, regRdData);
  endtask : acc
  task automatic drv(input logic [3:0] b, input logic [7:0] n);
    @(posedge clock);
    evt <= b;
    go <= n != 8'h0;
    len <= n;
    @(posedge clock);
    evt <= 4'h0;
    go <= 1'b0;
    repeat (n + 2) @(posedge clock);
  endtask : drv
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  initial forever #25 clock = ~clock;
  // The tests need some one hundred and twenty cycles, so two thousand leaves ample room.
  initial begin
    #100000;
    error_cnt++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 16; i += 2) acc(0, i[3:0], 32'h0);
    chk("srcBytes", 32'h10000, srcBytes);
    acc(1, REG_SRC_START, 32'h8000_1234);
    acc(1, REG_DST_START, 32'h1fff_fffc);
    acc(1, REG_SRC_SIZE, 32'h0001_ffff);
    chk("srcBytes", 32'hffff, srcBytes);
    acc(1, REG_SRC_SIZE, 32'hffff_0004);
    acc(0, REG_SRC_START, 32'h8000_1234);
    acc(0, REG_DST_START, 32'h1fff_fffc);
    acc(0, REG_SRC_SIZE, 32'h4);
    chk("srcStartAddr", 32'h8000_1234, srcStartAddr);
    chk("dstStartAddr", 32'h1fff_fffc, dstStartAddr);
    $display("setup test done");
    acc(1, REG_EVENT_CTRL, 32'h001f_001f);
    drv(4'h0, 8'h2);
    acc(0, REG_EVENT_CTRL, 32'h001f_0004);
    chk("irqOut", 32'h1, irqOut);
    acc(1, REG_EVENT_CTRL, 32'h001f_0000);
    chk("irqOut", 32'h0, irqOut);
    drv(4'h0, 8'h6);
    acc(0, REG_EVENT_CTRL, 32'h001f_001c);
    for (int i = 0; i < 4; i++) begin
      acc(1, REG_EVENT_CTRL, 32'h001f_0000);
      drv(4'h1 << i, 8'h0);
      acc(0, REG_EVENT_CTRL, 32'h001f_0000 | ((32'h8112 >> (4 * i)) & 32'hf));
      chk("irqOut", 32'h1, irqOut);
    end
    @(posedge clock);
    evt <= 4'h1;
    @(negedge clock);
    chk("abortTransfer", 32'h1, abortTransfer);
    @(posedge clock);
    evt <= 4'h0;
    acc(1, REG_EVENT_CTRL, 32'h0);
    drv(4'h4, 8'h0);
    chk("irqOut", 32'h0, irqOut);
    channelEnable <= 1'b0;
    drv(4'h8, 8'h2);
    evt <= 4'h1;
    @(negedge clock);
    chk("abortTransfer", 32'h0, abortTransfer);
    @(posedge clock);
    evt <= 4'h0;
    acc(0, REG_EVENT_CTRL, 32'h1);
    $display("event test done");
    @(posedge clock);
    rst <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
    acc(0, REG_SRC_START, 32'h0);
    chk("srcStartAddr", 32'h0, srcStartAddr);
    $display("reset test done");
    complete_run();
  end
endmodule : dma_channel_flags_and_setup_tb
